// *** core/pmb_addr_busy.sv ***
// How it works
// - Own address is base plus pin offset
// - Offset equals high select times three plus low
// - Base address register takes any written value
// - Base address resets to 0x5C
// - Global address always answered, alert response address answered on reads only
// - Common status readable even while busy
// - Busy collision records fault, alert low, drops command
// - While busy, ack address, nack command byte other than common status
// - Status bit 6 low while busy
// - Nonvolatile commands hold busy for their times
// - Busy timed from stop of triggering command
// - Setting writes busy just under 50 us
// - Clear faults accepted, flags cleared within bound
// - Refused command sets busy fault status flag
// - Fault log writing also makes device busy
// - Extra PEC byte and group framing tolerated
`timescale 1ns/1ps
module pmb_addr_busy
    import pmb_pkg::*;
#(
    parameter logic [BUSY_W-1:0] RESTORE_T = BUSY_W'(RESTORE_CYC),
    parameter logic [BUSY_W-1:0] FLOG_CLEAR_T = BUSY_W'(FLOG_CLEAR_CYC),
    parameter logic [BUSY_W-1:0] FLOG_STORE_T = BUSY_W'(FLOG_STORE_CYC),
    parameter logic [BUSY_W-1:0] FLOG_RESTORE_T = BUSY_W'(FLOG_RESTORE_CYC),
    parameter logic [BUSY_W-1:0] MASS_WRITE_T = BUSY_W'(MASS_WRITE_CYC),
    parameter logic [BUSY_W-1:0] NVM_T = BUSY_W'(NVM_CYC)
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link clock (oversamples the bus pins)
    input wire logic link_clk,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Three-level select pins, coded low/open/high
    input wire logic [1:0] addr_sel_low_pin,
    input wire logic [1:0] addr_sel_high_pin,
    // Base address write
    input wire logic base_wr,
    input wire logic [6:0] base_wdata,
    // Fault log being written to nonvolatile memory
    input wire logic flog_writing,
    // Command handed to the core
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_data,
    output logic [1:0] cmd_bytes,
    // Status
    output logic [6:0] own_addr,
    output logic busy_out,
    output logic busy_fault,
    output logic alert_n_out
);

    // ---- Core domain state ----
    logic [6:0] base_addr;       // Writable base address
    logic [1:0] strap_cnt;       // Settle count before strap capture
    logic strap_done;            // Offset has been captured
    logic [3:0] offset;          // Decoded pin offset, held until reset
    logic [3:0] sel_s;           // Synced select pins
    logic addr_tgl;              // Flips when own_addr changes
    logic [BUSY_W-1:0] busy_cnt; // Remaining busy cycles
    logic [2:0] ev_s;            // Synced link toggles
    logic [2:0] ev_d;            // Previous synced toggles

    // ---- Link domain state ----
    link_state_t state;
    logic [1:0] pin_s;           // Synced scl, sda, inverted so reset reads as idle high
    logic scl_d;
    logic sda_d;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;           // Receive shift register
    logic [7:0] tx;              // Transmit shift register
    logic rd;                    // Current address phase is a read
    logic is_ara;                // Current read is alert response
    logic rd_status;             // Last command was common status
    logic mack;                  // Host acked last read byte
    logic cmd_pend;              // A write command awaits stop
    logic [7:0] code_l;
    logic [15:0] data_l;
    logic [1:0] nbytes;
    logic cmd_tgl;
    logic fault_tgl;
    logic ara_tgl;
    logic [6:0] own_l;           // Link copy of own address
    logic addr_tgl_s;
    logic addr_tgl_d;
    logic busy_l;                // Synced busy level

    // Open-drain data: only ever pull low
    assign sda_out = 1'b0;

    // ================= Core domain =================

    // Select pins cross into clk before decode
    sync2 #(.W(4)) u_sel_sync (
        .clk(clk),
        .rst(rst),
        .d({addr_sel_high_pin, addr_sel_low_pin}),
        .q(sel_s)
    );

    // Level decode: low 0, open 1, high (or illegal) 2
    wire [3:0] lo_val = (sel_s[1:0] == LVL_LOW) ? 4'h0 : (sel_s[1:0] == LVL_OPEN) ? 4'h1 : 4'h2;
    wire [3:0] hi_val = (sel_s[3:2] == LVL_LOW) ? 4'h0 : (sel_s[3:2] == LVL_OPEN) ? 4'h1 : 4'h2;
    wire [3:0] next_offset = 4'(hi_val * SEL_WEIGHT) + lo_val;

    // Strap capture once the synchroniser has settled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            offset <= 4'h0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == STRAP_WAIT) begin
                strap_done <= 1'b1;
                offset <= next_offset;
            end
        end
    end

    // Base address register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_addr <= BASE_ADDR_RST;
        end else if (base_wr) begin
            base_addr <= base_wdata;
        end
    end

    // Own address; wraps in seven bits if base is set high
    wire [6:0] next_own = base_addr + {3'h0, offset};

    // Publish own address with a change toggle for the link side
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            own_addr <= BASE_ADDR_RST;
            addr_tgl <= 1'b0;
        end else begin
            own_addr <= next_own;
            if (next_own != own_addr) begin
                addr_tgl <= ~addr_tgl;
            end
        end
    end

    // Link events: command, busy fault, alert read
    sync2 #(.W(3)) u_ev_sync (
        .clk(clk),
        .rst(rst),
        .d({ara_tgl, fault_tgl, cmd_tgl}),
        .q(ev_s)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ev_d <= 3'h0;
        end else begin
            ev_d <= ev_s;
        end
    end

    wire cmd_ev = ev_s[0] ^ ev_d[0];
    wire fault_ev = ev_s[1] ^ ev_d[1];
    wire ara_ev = ev_s[2] ^ ev_d[2];
    // Link holds code_l steady long after its toggle, so reading it here is safe
    wire clr_ev = cmd_ev && (code_l == CMD_CLEAR_FAULTS);

    // Busy length per command; zero means no busy time
    wire [BUSY_W-1:0] next_busy_len =
        (code_l == CMD_STORE_ALL) ? MASS_WRITE_T :
        (code_l == CMD_RESTORE_ALL) ? RESTORE_T :
        (code_l == CMD_FLOG_CLEAR) ? FLOG_CLEAR_T :
        (code_l == CMD_FLOG_STORE) ? FLOG_STORE_T :
        (code_l == CMD_FLOG_RESTORE) ? FLOG_RESTORE_T :
        (code_l == CMD_NVM_ERASE || code_l == CMD_NVM_DATA) ? NVM_T :
        (code_l == CMD_CONFIG || code_l == CMD_RISE_TIME || code_l == CMD_OV_LIMIT ||
         code_l == CMD_UV_LIMIT || code_l == CMD_DAC) ? RAM_CYC : '0;

    // Busy timer starts at the stop that ends the command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt <= '0;
        end else if (cmd_ev) begin
            busy_cnt <= next_busy_len;
        end else if (busy_cnt != '0) begin
            busy_cnt <= busy_cnt - 1'b1;
        end
    end

    // Busy level, including external fault log writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (next_busy_len != '0 && cmd_ev) || (busy_cnt > 1) || flog_writing;
        end
    end

    // Command hand-off to the core, one pulse per stop that ends a pending write command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_valid <= 1'b0;
            cmd_code <= 8'h00;
            cmd_data <= 16'h0000;
            cmd_bytes <= 2'h0;
        end else begin
            cmd_valid <= cmd_ev;
            if (cmd_ev) begin
                cmd_code <= code_l;
                cmd_data <= data_l;
                cmd_bytes <= nbytes;
            end
        end
    end

    // Fault flags; a new fault beats a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_fault <= 1'b0;
            alert_n_out <= 1'b1;
        end else begin
            if (fault_ev) begin
                busy_fault <= 1'b1;
                alert_n_out <= 1'b0;
            end else begin
                // Clear lands a few cycles after stop, well inside 500 us
                if (clr_ev) begin
                    busy_fault <= 1'b0;
                end
                if (clr_ev || ara_ev) begin
                    alert_n_out <= 1'b1;
                end
            end
        end
    end

    // ================= Link domain =================

    // Pins and core levels cross into link_clk
    sync2 #(.W(2)) u_pin_sync (
        .clk(link_clk),
        .rst(rst),
        .d(~{scl_in, sda_in}),
        .q(pin_s)
    );

    sync2 #(.W(2)) u_core_sync (
        .clk(link_clk),
        .rst(rst),
        .d({addr_tgl, busy_out}),
        .q({addr_tgl_s, busy_l})
    );

    // Inverted back; a cleared synchroniser must not fake a clock fall after reset
    wire scl_s = !pin_s[1];
    wire sda_s = !pin_s[0];

    // Edge history and own-address copy
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            addr_tgl_d <= 1'b0;
            own_l <= BASE_ADDR_RST;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            addr_tgl_d <= addr_tgl_s;
            // own_addr is steady for many cycles after its toggle flips
            if (addr_tgl_s != addr_tgl_d) begin
                own_l <= own_addr;
            end
        end
    end

    // Bus conditions
    wire start_c = scl_s && scl_d && sda_d && !sda_s;
    wire stop_c = scl_s && scl_d && !sda_d && sda_s;
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire byte_in = scl_fall && (bit_cnt == 4'h8);

    // Address match on the received byte
    wire own_hit = (shreg[7:1] == own_l);
    wire ara_hit = (shreg[7:1] == ARA_ADDR) && shreg[0];
    wire addr_hit = own_hit || (shreg[7:1] == GLOBAL_ADDR) || ara_hit;
    wire refuse = busy_l && (shreg != CMD_COMMON);

    // First read byte: own address, status, or fill
    wire [7:0] status_byte = 8'({7'h00, !busy_l} << STATUS_READY_BIT);
    wire [7:0] next_tx = is_ara ? {own_l, 1'b0} : rd_status ? status_byte : RD_FILL;

    // Byte-level slave machine
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            state <= L_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'hFF;
            sda_oe <= 1'b0;
            rd <= 1'b0;
            is_ara <= 1'b0;
            rd_status <= 1'b0;
            mack <= 1'b0;
            cmd_pend <= 1'b0;
            code_l <= 8'h00;
            data_l <= 16'h0000;
            nbytes <= 2'h0;
            cmd_tgl <= 1'b0;
            fault_tgl <= 1'b0;
            ara_tgl <= 1'b0;
        end else if (start_c) begin
            // Repeated start keeps a pending command for group framing
            state <= L_ADDR;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            state <= L_IDLE;
            sda_oe <= 1'b0;
            if (cmd_pend) begin
                cmd_tgl <= ~cmd_tgl;
                cmd_pend <= 1'b0;
            end
        end else begin
            if (scl_rise && (state == L_ADDR || state == L_CMD || state == L_WDATA)) begin
                shreg <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
            case (state)
                L_ADDR: begin
                    if (byte_in) begin
                        bit_cnt <= 4'h0;
                        if (addr_hit) begin
                            // Address is acked even while busy
                            sda_oe <= 1'b1;
                            rd <= shreg[0];
                            is_ara <= ara_hit;
                            state <= L_ADDR_ACK;
                            if (shreg[0]) begin
                                // A read never executes the command it named
                                cmd_pend <= 1'b0;
                            end
                        end else begin
                            state <= L_WAIT;
                        end
                    end
                end
                L_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rd) begin
                            sda_oe <= !next_tx[7];
                            tx <= {next_tx[6:0], 1'b1};
                            bit_cnt <= 4'h1;
                            state <= L_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= L_CMD;
                        end
                    end
                end
                L_CMD: begin
                    if (byte_in) begin
                        bit_cnt <= 4'h0;
                        if (refuse) begin
                            // Not acked and dropped
                            fault_tgl <= ~fault_tgl;
                            state <= L_WAIT;
                        end else begin
                            sda_oe <= 1'b1;
                            code_l <= shreg;
                            rd_status <= (shreg == CMD_COMMON);
                            cmd_pend <= (shreg != CMD_COMMON);
                            nbytes <= 2'h0;
                            state <= L_CMD_ACK;
                        end
                    end
                end
                L_CMD_ACK, L_WDATA_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        state <= L_WDATA;
                    end
                end
                L_WDATA: begin
                    if (byte_in) begin
                        bit_cnt <= 4'h0;
                        sda_oe <= 1'b1;
                        state <= L_WDATA_ACK;
                        // Only two data bytes kept; a PEC byte is acked and dropped
                        if (nbytes == 2'h0) begin
                            data_l[7:0] <= shreg;
                        end else if (nbytes == 2'h1) begin
                            data_l[15:8] <= shreg;
                        end
                        if (nbytes != 2'h3) begin
                            nbytes <= nbytes + 2'h1;
                        end
                    end
                end
                L_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe <= 1'b0;
                            state <= L_RACK;
                        end else begin
                            sda_oe <= !tx[7];
                            tx <= {tx[6:0], 1'b1};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                L_RACK: begin
                    if (scl_rise) begin
                        mack <= !sda_s;
                        if (is_ara) begin
                            ara_tgl <= ~ara_tgl;
                            is_ara <= 1'b0;
                        end
                    end else if (scl_fall) begin
                        if (mack) begin
                            // Further bytes read as fill
                            tx <= RD_FILL;
                            bit_cnt <= 4'h1;
                            state <= L_RDATA;
                        end else begin
                            state <= L_WAIT;
                        end
                    end
                end
                default: begin
                    // Idle or ignoring until next start or stop
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule // pmb_addr_busy

// *** core/sync2.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage is read from outside it
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta; // First stage, read only by q

    // Plain double flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sync2

// *** pkg/pmb_pkg.sv ***
package pmb_pkg;

    // Bus addresses (7-bit)
    localparam logic [6:0] BASE_ADDR_RST = 7'h5C;  // Factory default base address
    localparam logic [6:0] GLOBAL_ADDR = 7'h5B;    // Always-answered global address
    localparam logic [6:0] ARA_ADDR = 7'h0C;       // Alert response address

    // Command codes
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STORE_ALL = 8'h15;
    localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
    localparam logic [7:0] CMD_UV_LIMIT = 8'h44;
    localparam logic [7:0] CMD_COMMON = 8'hF1;      // Common status command
    localparam logic [7:0] CMD_FLOG_CLEAR = 8'hEC;
    localparam logic [7:0] CMD_FLOG_STORE = 8'hEA;
    localparam logic [7:0] CMD_FLOG_RESTORE = 8'hEB;
    localparam logic [7:0] CMD_CONFIG = 8'hD2;
    localparam logic [7:0] CMD_RISE_TIME = 8'h61;
    localparam logic [7:0] CMD_DAC = 8'hE0;
    localparam logic [7:0] CMD_NVM_ERASE = 8'hBD;   // user_nvm_erase_cmd
    localparam logic [7:0] CMD_NVM_DATA = 8'hBF;    // user_nvm_data_cmd

    // Status byte layout
    localparam int STATUS_READY_BIT = 6;           // High when commands are accepted
    localparam logic [7:0] RD_FILL = 8'hFF;        // Returned for bytes with no data

    // Three-level select pin codes
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_OPEN = 2'h1;
    localparam logic [3:0] SEL_WEIGHT = 4'h3;      // Offset = high * 3 + low

    // Timing, microseconds as printed, and clock rate
    localparam int CLK_MHZ = 40;
    localparam int T_RESTORE_US = 30000;
    localparam int T_FLOG_CLEAR_US = 175000;
    localparam int T_FLOG_STORE_US = 20000;
    localparam int T_FLOG_RESTORE_US = 2000;
    localparam int T_MASS_WRITE_US = 100000;
    localparam int T_NVM_US = 100000;
    localparam int T_RAM_US = 50;

    // Busy counts in clk cycles
    localparam int BUSY_W = 23;
    localparam int RESTORE_CYC = T_RESTORE_US * CLK_MHZ;
    localparam int FLOG_CLEAR_CYC = T_FLOG_CLEAR_US * CLK_MHZ;
    localparam int FLOG_STORE_CYC = T_FLOG_STORE_US * CLK_MHZ;
    localparam int FLOG_RESTORE_CYC = T_FLOG_RESTORE_US * CLK_MHZ;
    localparam int MASS_WRITE_CYC = T_MASS_WRITE_US * CLK_MHZ;
    localparam int NVM_CYC = T_NVM_US * CLK_MHZ;
    // Strictly under the printed bound, so one cycle short of it
    localparam logic [BUSY_W-1:0] RAM_CYC = BUSY_W'(T_RAM_US * CLK_MHZ - 1);

    // Strap settle count after reset release
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // Link state machine, Gray along the usual path
    typedef enum logic [3:0] {
        L_IDLE = 4'h0,
        L_ADDR = 4'h1,
        L_ADDR_ACK = 4'h3,
        L_CMD = 4'h2,
        L_CMD_ACK = 4'h6,
        L_WDATA = 4'h7,
        L_WDATA_ACK = 4'h5,
        L_RDATA = 4'h4,
        L_RACK = 4'hC,
        L_WAIT = 4'hD
    } link_state_t;

endpackage

// *** test/pmb_addr_busy_bench.sv ***
`timescale 1ns/1ps
module pmb_addr_busy_bench
    import pmb_pkg::*;
;
    // Busy counts handed to the design, short to keep the run brief
    localparam int L[6] = '{200, 260, 320, 380, 440, 500};
    localparam logic [7:0] C[6] = '{CMD_RESTORE_ALL, CMD_FLOG_CLEAR, CMD_FLOG_STORE, CMD_FLOG_RESTORE,
        CMD_STORE_ALL, CMD_NVM_ERASE};
    logic clk = 0, link_clk = 0, rst = 1, base_wr = 0, flog_writing = 0, ack, scl_in, sda_h;
    logic sda_oe, cmd_valid, busy_out, busy_fault, alert_n_out;
    logic [1:0] addr_sel_low_pin, addr_sel_high_pin, cmd_bytes;
    logic [6:0] base_wdata = 7'h00, off, base, own_addr;
    logic [7:0] cmd_code, v;
    logic [15:0] cmd_data;
    logic [25:0] e, q[$];
    logic [31:0] lfsr = 32'h74B2;
    int mismatches = 0, checks = 0, cyc = 0, cv = 0, n;
    wire sda_in = sda_h & ~sda_oe; // Pulled up, low while either side pulls
    pmb_addr_busy #(.RESTORE_T(BUSY_W'(L[0])), .FLOG_CLEAR_T(BUSY_W'(L[1])), .FLOG_STORE_T(BUSY_W'(L[2])),
        .FLOG_RESTORE_T(BUSY_W'(L[3])), .MASS_WRITE_T(BUSY_W'(L[4])), .NVM_T(BUSY_W'(L[5])))
        uut (.*, .sda_out());
    pmb_host h (.scl(scl_in), .sda_h(sda_h), .sda(sda_in));
    initial forever #12.5 clk = ~clk;
    initial begin
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic cmp(input string s, input logic [15:0] x, input logic [15:0] y);
        checks++;
        if (x !== y) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", s, x, y);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Write; the host skips the data bytes when ok marks the command byte as one to be refused
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input int nb, input logic [15:0] d, input logic ok);
        h.start();
        h.wbyte({a, 1'b0}, ack);
        cmp("addr_ack", 1'b1, ack);
        h.wbyte(c, ack);
        cmp("cmd_ack", ok, ack);
        for (int k = 0; k < nb && ok; k++) h.wbyte(d[8*k+:8], ack);
        if (ok) q.push_back({2'(nb), c, d});
        h.stop();
        repeat (8) @(posedge clk);
    endtask
    // Read; status read goes through a repeated start, alert read is direct
    task automatic rd(input logic [6:0] a, input logic sr);
        if (sr) begin
            h.start();
            h.wbyte({a, 1'b0}, ack);
            h.wbyte(CMD_COMMON, ack);
        end
        h.start();
        h.wbyte({a, 1'b1}, ack);
        cmp("rd_ack", 1'b1, ack);
        h.rbyte(v, sr);
        h.stop();
        repeat (8) @(posedge clk);
    endtask
    // Bounded wait for busy to end; n is cycles since the last handoff
    task automatic idle();
        for (int k = 0; k < 3000 && busy_out !== 1'b0; k++) @(negedge clk);
        n = cyc - cv;
    endtask
    // Watcher: each handoff takes the oldest note off the queue
    always @(negedge clk) begin
        if (cmd_valid === 1'b1) begin
            cv = cyc;
            e = q.pop_front();
            cmp("cmd_code", e[23:16], cmd_code);
            cmp("cmd_bytes", e[25:24], cmd_bytes);
            if (e[25]) cmp("cmd_data", e[15:0], cmd_data);
        end
    end
    // Cycle ceiling far past the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        void'(rnd());
        addr_sel_low_pin = lfsr[1:0];
        addr_sel_high_pin = lfsr[3:2];
        off = 7'(addr_sel_high_pin[1] ? 2'h2 : addr_sel_high_pin) * 7'h3
            + 7'(addr_sel_low_pin[1] ? 2'h2 : addr_sel_low_pin);
        repeat (12) @(posedge clk);
        #2 rst = 1'b0;
        repeat (30) @(posedge clk);
        base = BASE_ADDR_RST + off;
        cmp("own_addr", base, own_addr);
        wr(base, CMD_CONFIG, 2, 16'(rnd()), 1'b1);
        cmp("busy", 1'b1, busy_out);
        rd(base, 1'b1);
        cmp("status", 8'h00, v);
        wr(base, CMD_OV_LIMIT, 2, 16'h0000, 1'b0);
        cmp("fault", 1'b1, busy_fault);
        cmp("alert", 1'b0, alert_n_out);
        idle();
        cmp("ram_len", 1'b1, n <= 2001);
        rd(base, 1'b1);
        cmp("status", 8'h40, v);
        rd(ARA_ADDR, 1'b0);
        cmp("ara", {base, 1'b0}, v);
        cmp("alert", 1'b1, alert_n_out);
        wr(GLOBAL_ADDR, CMD_CLEAR_FAULTS, 0, 16'h0000, 1'b1);
        cmp("fault", 1'b0, busy_fault);
        @(posedge clk);
        #2 base_wr = 1'b1;
        base_wdata = 7'(rnd());
        base = base_wdata + off;
        @(posedge clk);
        #2 base_wr = 1'b0;
        repeat (4) @(posedge clk);
        cmp("own_addr", base, own_addr);
        for (int i = 0; i < 6; i++) begin
            wr(base, C[i], 0, 16'h0000, 1'b1);
            idle();
            cmp("nvm_len", 1'b1, n >= L[i] - 1 && n <= L[i] + 2);
        end
        @(posedge clk);
        #2 flog_writing = 1'b1;
        wr(base, CMD_DAC, 0, 16'h0000, 1'b0);
        rd(base, 1'b1);
        cmp("status", 8'h00, v);
        @(posedge clk);
        #2 flog_writing = 1'b0;
        idle();
        wr(base, CMD_DAC, 2, 16'(rnd()), 1'b1);
        idle();
        cmp("queue", 16'h0000, 16'(q.size()));
        end_of_test();
    end
endmodule // pmb_addr_busy_bench

// *** test/pmb_addr_busy_monitor.sv ***
`timescale 1ns/1ps
module pmb_addr_busy_monitor
    import pmb_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic rst,
    // Inputs
    input logic [1:0] addr_sel_low_pin,
    input logic [1:0] addr_sel_high_pin,
    input logic base_wr,
    input logic [6:0] base_wdata,
    input logic flog_writing,
    // Outputs
    input logic cmd_valid,
    input logic [7:0] cmd_code,
    input logic [6:0] own_addr,
    input logic busy_out,
    input logic busy_fault,
    input logic alert_n_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Straps stand still after reset, so the live pins give the offset
    wire [6:0] off = 7'(addr_sel_high_pin[1] ? 2'h2 : addr_sel_high_pin) * 7'h3
        + 7'(addr_sel_low_pin[1] ? 2'h2 : addr_sel_low_pin);
    property p_base; base_wr |-> ##[2:3] own_addr == $past(base_wdata, 2) + off; endproperty
    a_base: assert property (p_base) else $error("own address wrong");
    property p_stat; cmd_valid |-> cmd_code != CMD_COMMON; endproperty
    a_stat: assert property (p_stat) else $error("status read handed on");
    property p_ram; cmd_valid && cmd_code == CMD_DAC |=> busy_out [*8]; endproperty
    a_ram: assert property (p_ram) else $error("setting write not busy");
    property p_nvm; cmd_valid && cmd_code == CMD_RESTORE_ALL |=> busy_out; endproperty
    a_nvm: assert property (p_nvm) else $error("restore not busy");
    property p_flog; flog_writing |-> ##[1:2] busy_out; endproperty
    a_flog: assert property (p_flog) else $error("log write not busy");
    property p_free; $fell(busy_out) |-> $past(flog_writing) == 1'b0; endproperty
    a_free: assert property (p_free) else $error("busy ended in log write");
    property p_alert; $rose(busy_fault) |-> ##[0:2] !alert_n_out; endproperty
    a_alert: assert property (p_alert) else $error("no alert on fault");
    property p_keep; $rose(busy_fault) |=> busy_fault [*8]; endproperty
    a_keep: assert property (p_keep) else $error("fault not held");
    c_cmd: cover property (cmd_valid);
    c_fault: cover property ($rose(busy_fault));
    c_ara: cover property ($rose(alert_n_out));
endmodule // pmb_addr_busy_monitor
bind pmb_addr_busy pmb_addr_busy_monitor mon (.*);

// *** test/pmb_host_model.sv ***
`timescale 1ns/1ps
// Bus host: drives the clock, pulls data low, releases it high to the pull-up
module pmb_host (
    // Bus lines
    output logic scl,
    output logic sda_h,
    input logic sda
);
    localparam int T = 200; // Half bit, far above four link clocks
    initial {scl, sda_h} = 2'h3;
    // Start or repeated start; the clock stands still between frames
    task automatic start();
        sda_h = 1'b1;
        #T scl = 1'b1;
        #T sda_h = 1'b0;
        #T scl = 1'b0;
    endtask
    // Stop ends the frame, so any busy time runs from here
    task automatic stop();
        #(T / 2) sda_h = 1'b0;
        #T scl = 1'b1;
        #T sda_h = 1'b1;
        #T;
    endtask
    // Nine bits: data moves while the clock is low, sampled late in the high
    task automatic xfer(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--) begin
            #(T / 2) sda_h = o[k];
            #(T / 2) scl = 1'b1;
            #T i[k] = sda;
            scl = 1'b0;
        end
    endtask
    task automatic wbyte(input logic [7:0] b, output logic a);
        logic [8:0] i;
        xfer({b, 1'b1}, i);
        a = ~i[0];
    endtask
    task automatic rbyte(output logic [7:0] b, input logic nack);
        logic [8:0] i;
        xfer({8'hFF, nack}, i);
        b = i[8:1];
    endtask
endmodule // pmb_host
